// ==== faebp_core.sv ====
// address extension register and program/erase protection gate.
// assumes a host in clock mode 0 on sclk_i framed by cs_n_i, and that
// the protection and power-up bits come from logic on mclk_i.
//
// Function
// - an 8-bit volatile upper address byte is read with C8h and written with C5h.
// - the upper address byte feeds addressing only in 3-byte mode.
// - in 3-byte mode the byte selects one of 256 16 MB regions above the 24-bit address.
// - instructions with their own 4-byte address take the top byte from the frame.
// - after power-up with 4-byte selected or after B7h every addressed command takes 4 bytes.
// - a received fourth address byte never alters the stored upper byte.
// - the upper byte clears to zero at power-up and after software or hardware reset.
// - without inversion levels 1..12 protect 2^(k-1) blocks at top or bottom, 13..15 all.
// - with inversion the protected set is the complement, level 0 all, level 13 none.
// - program or erase touching any protected block is discarded.
// - the address mode flag reads 0 in 3-byte mode and 1 in 4-byte mode.
// - the power-up selector picks 3-byte mode when 0 and 4-byte mode when 1.
`default_nettype none

module faebp_core
   import faebp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_n_o,
   input wire logic protect_invert_i,
   input wire logic protect_from_bottom_i,
   input wire logic protect_level_bit3_i,
   input wire logic protect_level_bit2_i,
   input wire logic protect_level_bit1_i,
   input wire logic protect_level_bit0_i,
   input wire logic powerup_addr_width_sel_i,
   output logic current_addr_width_flag_o,
   output logic [7:0] upper_address_byte_o,
   output faebp_op_t op_o
);

   // ****************************************************************
   // state types
   // ****************************************************************
   typedef struct packed {
      logic [5:0] cnt;
      logic [7:0] cmd;
      logic [31:0] addr;
      logic [7:0] out;
   } faebp_link_st_t;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic boot;
      logic [7:0] upper_address_byte;
      logic addr4;
      logic rst_armed;
      faebp_op_t op;
   } faebp_core_st_t;

   localparam faebp_core_st_t CORE_RESET = '{1'b1, 1'b1, 1'b1, 1'b1,
      EXT_RESET, 1'b0, 1'b0, OP_IDLE};

   faebp_link_st_t lk;
   faebp_link_st_t next_lk;
   faebp_core_st_t st;
   faebp_core_st_t next_st;
   logic fresh;
   logic [5:0] base;
   faebp_prot_t prot;

   // ****************************************************************
   // link side, clocked by the host serial clock
   // ****************************************************************
   // the clock stops between frames, so a new frame is flagged by an
   // async set from chip select rather than by a counter reset
   always_ff @(posedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
         fresh <= 1'b1;
      else
         fresh <= 1'b0;
   end

   // shift command then up to four address bytes, then hold
   always_comb
   begin
      next_lk = lk;
      base = fresh ? 6'h00 : lk.cnt;
      if (base != BITS_MAX)
         next_lk.cnt = base + 6'h01;
      if (base < BITS_CMD)
         next_lk.cmd = {lk.cmd[6:0], si_i};
      else if (base < BITS_ADDR4)
         next_lk.addr = {lk.addr[30:0], si_i};
      next_lk.out = {lk.out[6:0], 1'b0};
      // read-out of the upper byte
      // the byte only changes while chip select is high, so it is
      // stable for the whole frame when loaded here
      if (base == BITS_CMD - 6'h01 && {lk.cmd[6:0], si_i} == CMD_RD_EXT)
         next_lk.out = st.upper_address_byte;
   end

   always_ff @(posedge sclk_i)
   begin
      lk <= next_lk;
   end

   // data moves on the rising edge, so the host samples it one edge on
   assign so_o = lk.out[7];
   assign so_oe_n_o = ~(~cs_n_i & ~fresh & (lk.cmd == CMD_RD_EXT)
      & (lk.cnt >= BITS_CMD));

   // ****************************************************************
   // protection decode
   // ****************************************************************
   faebp_prot_dec u_prot_dec (
      .invert_i(protect_invert_i),
      .from_bottom_i(protect_from_bottom_i),
      .level_i({protect_level_bit3_i, protect_level_bit2_i,
         protect_level_bit1_i, protect_level_bit0_i}),
      .range_o(prot)
   );

   // ****************************************************************
   // core side, frame decode on chip select release
   // ****************************************************************
   logic frame_end;
   logic four_form;
   logic need4;
   logic addr_ok;
   logic [31:0] eff;
   logic [11:0] blo;
   logic [11:0] bhi;
   logic hit;
   faebp_kind_t kind;

   // classify the finished frame and form its effective address
   always_comb
   begin
      kind = OPK_NONE;
      four_form = 1'b0;
      case (lk.cmd)
         CMD_PP, CMD_QPP: kind = OPK_PAGE;
         CMD_PP4:
         begin
            kind = OPK_PAGE;
            four_form = 1'b1;
         end
         CMD_SE: kind = OPK_SECT;
         CMD_SE4:
         begin
            kind = OPK_SECT;
            four_form = 1'b1;
         end
         CMD_BE32: kind = OPK_BLK32;
         CMD_BE64: kind = OPK_BLK64;
         CMD_BE64_4:
         begin
            kind = OPK_BLK64;
            four_form = 1'b1;
         end
         CMD_CE_A, CMD_CE_B: kind = OPK_CHIP;
         default: kind = OPK_NONE;
      endcase
      need4 = four_form | st.addr4;
      eff = 32'h00000000;
      addr_ok = 1'b0;
      if (kind == OPK_CHIP)
         addr_ok = lk.cnt >= BITS_CMD;
      else if (need4)
      begin
         // top byte from the frame itself
         addr_ok = lk.cnt >= BITS_ADDR4;
         eff = lk.addr;
      end
      else if (lk.cnt == BITS_ADDR3)
      begin
         // upper byte used only in 3-byte mode
         // upper byte selects the 16 MB region
         addr_ok = 1'b1;
         eff = {st.upper_address_byte, lk.addr[23:0]};
      end
      else if (lk.cnt >= BITS_ADDR4)
      begin
         // a data byte followed; the address sits one byte higher
         addr_ok = 1'b1;
         eff = {st.upper_address_byte, lk.addr[31:8]};
      end
      // every region up to 64 KB lies inside one block
      blo = (kind == OPK_CHIP) ? BLK_FIRST : eff[BLK_MSB:BLK_LSB];
      bhi = (kind == OPK_CHIP) ? BLK_LAST : eff[BLK_MSB:BLK_LSB];
      // any overlap with the protected range
      hit = prot.any && !(bhi < prot.lo || blo > prot.hi);
   end

   // register commit: sync chip select, apply frame effects
   always_comb
   begin
      next_st = st;
      next_st.op.valid = 1'b0;
      next_st.op.reject = 1'b0;
      next_st.cs_s1 = cs_n_i;
      next_st.cs_s2 = st.cs_s1;
      next_st.cs_s3 = st.cs_s2;
      frame_end = st.cs_s2 & ~st.cs_s3;
      if (st.boot)
      begin
         // power-up strap taken just after reset release
         next_st.boot = 1'b0;
         next_st.addr4 = powerup_addr_width_sel_i;
      end
      if (frame_end)
      begin
         // reset enable only arms the very next instruction
         next_st.rst_armed = 1'b0;
         case (lk.cmd)
            CMD_WR_EXT:
            begin
               // write needs exactly one whole data byte
               if (lk.cnt == BITS_WR_EXT)
                  next_st.upper_address_byte = lk.addr[7:0];
            end
            CMD_ENTER4:
            begin
               if (lk.cnt >= BITS_CMD)
                  next_st.addr4 = 1'b1;
            end
            CMD_EXIT4:
            begin
               if (lk.cnt >= BITS_CMD)
                  next_st.addr4 = 1'b0;
            end
            CMD_RST_EN:
            begin
               if (lk.cnt >= BITS_CMD)
                  next_st.rst_armed = 1'b1;
            end
            CMD_RST:
            begin
               // software reset clears the upper byte
               if (lk.cnt >= BITS_CMD && st.rst_armed)
               begin
                  next_st.upper_address_byte = EXT_RESET;
                  next_st.addr4 = powerup_addr_width_sel_i;
               end
            end
            default: next_st.rst_armed = 1'b0;
         endcase
         // the 4-byte path never writes the stored byte
         if (kind != OPK_NONE && addr_ok)
         begin
            // protected targets are reported and dropped
            next_st.op.valid = ~hit;
            next_st.op.reject = hit;
            next_st.op.kind = kind;
            next_st.op.addr = eff;
         end
      end
   end

   // power-up or hardware reset loads CORE_RESET into the core side; the link side has no reset
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         st <= CORE_RESET;
      else
         st <= next_st;
   end

   // mode flag mirrors the active address width
   assign current_addr_width_flag_o = st.addr4;
   assign upper_address_byte_o = st.upper_address_byte;
   assign op_o = st.op;

endmodule

`default_nettype wire

// ==== faebp_core_monitor.sv ====
// port assertions for the extension byte and protection gate
// assumes it is bound onto faebp_core and sampled on mclk_i
`default_nettype none
module faebp_core_monitor
   import faebp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic so_oe_n_o,
   input wire logic protect_invert_i,
   input wire logic protect_level_bit3_i,
   input wire logic protect_level_bit2_i,
   input wire logic protect_level_bit1_i,
   input wire logic protect_level_bit0_i,
   input wire logic powerup_addr_width_sel_i,
   input wire logic current_addr_width_flag_o,
   input wire logic [7:0] upper_address_byte_o,
   input wire faebp_op_t op_o
);
   logic [3:0] lvl;
   logic pulse;
   // level and op pulse gathered once; levels only move between frames
   assign lvl = {protect_level_bit3_i, protect_level_bit2_i,
      protect_level_bit1_i, protect_level_bit0_i};
   assign pulse = op_o.valid | op_o.reject;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   chk_reset_clear: assert property ($fell(rst_i) |->
      upper_address_byte_o == EXT_RESET) else $error("byte not cleared");
   chk_strap_load: assert property ($fell(rst_i) |=>
      current_addr_width_flag_o == $past(powerup_addr_width_sel_i))
      else $error("mode not taken from strap");
   chk_pulse_once: assert property (op_o.valid |=> !pulse)
      else $error("op pulse too long");
   chk_oe_idle: assert property (cs_n_i |-> so_oe_n_o)
      else $error("data out driven outside a frame");
   // of the addressed kinds only the 32 KB erase has no four-byte form, so only its report is
   // certain to carry the stored byte while in 3-byte mode
   chk_ext_used: assert property (pulse && op_o.kind == OPK_BLK32
      && !current_addr_width_flag_o |->
      op_o.addr[31:24] == upper_address_byte_o)
      else $error("upper byte not applied");
   chk_full_prot: assert property (pulse && !protect_invert_i
      && lvl >= LEVEL_FULL |-> op_o.reject) else $error("not rejected");
   chk_inv_none: assert property (pulse && protect_invert_i
      && lvl >= LEVEL_FULL |-> op_o.valid) else $error("not accepted");
   chk_zero_lvl: assert property (pulse && lvl == LEVEL_NONE |->
      op_o.reject == protect_invert_i) else $error("level zero wrong");
   cover property (op_o.reject);
   cover property (op_o.valid && current_addr_width_flag_o);
   cover property ($rose(current_addr_width_flag_o));
endmodule
bind faebp_core faebp_core_monitor faebp_core_monitor_inst (
   .mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .so_oe_n_o(so_oe_n_o), .protect_invert_i(protect_invert_i),
   .protect_level_bit3_i(protect_level_bit3_i),
   .protect_level_bit2_i(protect_level_bit2_i),
   .protect_level_bit1_i(protect_level_bit1_i),
   .protect_level_bit0_i(protect_level_bit0_i),
   .powerup_addr_width_sel_i(powerup_addr_width_sel_i),
   .current_addr_width_flag_o(current_addr_width_flag_o),
   .upper_address_byte_o(upper_address_byte_o), .op_o(op_o));
`default_nettype wire

// ==== faebp_core_tb.sv ====
// self-checking bench for the extension byte and protection gate
// assumes the host model drives the link; core clock 125 MHz
`default_nettype none
module faebp_core_tb
   import faebp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, sclk, cs_n, si, so, so_oe_n, inv, bot, strap, flag;
   logic last_rej;
   logic [3:0] lvl;
   logic [7:0] ubyte, rd;
   faebp_op_t op;
   int mismatches, n_tests, n_ops;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end
   always #4 mclk = ~mclk;
   faebp_core faebp_core_inst (.mclk_i(mclk), .rst_i(rst), .sclk_i(sclk),
      .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
      .protect_invert_i(inv), .protect_from_bottom_i(bot),
      .protect_level_bit3_i(lvl[3]), .protect_level_bit2_i(lvl[2]),
      .protect_level_bit1_i(lvl[1]), .protect_level_bit0_i(lvl[0]),
      .powerup_addr_width_sel_i(strap), .current_addr_width_flag_o(flag),
      .upper_address_byte_o(ubyte), .op_o(op));
   faebp_host_model faebp_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n),
      .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n));
   // valid and reject last one cycle, so latch each one as it passes
   always @(posedge mclk)
      if (op.valid || op.reject)
      begin
         n_ops++;
         last_rej = op.reject;
      end
   task automatic frm(input logic [39:0] d, input int n);
      faebp_host_model_inst.xfer(d, n, rd);
   endtask
   task automatic setp(input logic iv, input logic bt, input logic [3:0] lv);
      @(posedge mclk);
      inv <= iv;
      bot <= bt;
      lvl <= lv;
      @(posedge mclk);
   endtask
   // kind reported for each program or erase instruction code
   function automatic faebp_kind_t exp_kind(input logic [7:0] c);
      case (c)
         CMD_PP, CMD_QPP, CMD_PP4: return OPK_PAGE;
         CMD_SE, CMD_SE4: return OPK_SECT;
         CMD_BE32: return OPK_BLK32;
         CMD_BE64, CMD_BE64_4: return OPK_BLK64;
         default: return OPK_CHIP;
      endcase
   endfunction
   // one program or erase frame: exactly one report, outcome and address
   task automatic opc(input logic [39:0] d, input int n, input logic er,
      input logic [31:0] ea);
      int c;
      c = n_ops;
      frm(d, n);
      `CHK(n_ops, c + 1)
      `CHK(last_rej, er)
      `CHK(op.addr, ea)
      `CHK(op.kind, exp_kind(d[39:32]))
   endtask
   function automatic logic exp_prot(input logic iv, input logic bt,
      input logic [3:0] lv, input logic [11:0] b);
      logic p;
      logic [12:0] n;
      n = 13'h0001 << (lv - 4'h1);
      if (lv == LEVEL_NONE)
         p = 1'b0;
      else if (lv >= LEVEL_FULL)
         p = 1'b1;
      else
         p = bt ? {1'b0, b} < n : {1'b0, b} >= 13'h1000 - n;
      return iv ^ p;
   endfunction
   // ****************
   // scenarios
   // ****************
   task automatic t_ext();
      `CHK(ubyte, EXT_RESET)
      `CHK(flag, 1'b0)
      frm({CMD_WR_EXT, 8'h5A, 24'h0}, 16);
      `CHK(ubyte, 8'h5A)
      frm({CMD_RD_EXT, 32'h0}, 16);
      `CHK(rd, 8'h5A)
      frm({CMD_WR_EXT, 8'h11, 24'h0}, 24);
      `CHK(ubyte, 8'h5A)
      $display("register test done");
   endtask
   task automatic t_addr();
      setp(1'b0, 1'b0, 4'h1);
      frm({CMD_WR_EXT, 8'h0F, 24'h0}, 16);
      opc({CMD_BE64, 24'hFF0000, 8'h0}, 32, 1'b1, 32'h0FFF0000);
      frm({CMD_WR_EXT, 8'h0E, 24'h0}, 16);
      opc({CMD_PP, 24'hFF0010, 8'hAB}, 40, 1'b0, 32'h0EFF0010);
      opc({CMD_SE, 24'h001000, 8'h0}, 32, 1'b0, 32'h0E001000);
      opc({CMD_BE32, 24'hFF8000, 8'h0}, 32, 1'b0, 32'h0EFF8000);
      opc({CMD_QPP, 24'h000100, 8'h55}, 40, 1'b0, 32'h0E000100);
      // four-byte forms in 3-byte mode ignore the stored 0E byte
      opc({CMD_PP4, 32'h03FF0000}, 40, 1'b0, 32'h03FF0000);
      opc({CMD_BE64_4, 32'h0FFF0000}, 40, 1'b1, 32'h0FFF0000);
      opc({CMD_CE_A, 32'h0}, 8, 1'b1, 32'h00000000);
      setp(1'b0, 1'b0, 4'h0);
      opc({CMD_CE_B, 32'h0}, 8, 1'b0, 32'h00000000);
      setp(1'b0, 1'b0, 4'h1);
      frm({CMD_ENTER4, 32'h0}, 8);
      `CHK(flag, 1'b1)
      opc({CMD_SE4, 32'h0FFF1234}, 40, 1'b1, 32'h0FFF1234);
      opc({CMD_BE64, 32'h00010000}, 40, 1'b0, 32'h00010000);
      `CHK(ubyte, 8'h0E)
      frm({CMD_EXIT4, 32'h0}, 8);
      `CHK(flag, 1'b0)
      $display("address test done");
   endtask
   // probe both sides of the protected edge for levels 1 to 12, and both array ends for levels 0 and 13 to 15
   task automatic t_prot();
      logic [11:0] n, p;
      frm({CMD_ENTER4, 32'h0}, 8);
      for (int iv = 0; iv < 2; iv++)
         for (int bt = 0; bt < 2; bt++)
            for (int lv = 0; lv < 16; lv++)
               for (int k = 0; k < 2; k++)
               begin
                  setp(iv[0], bt[0], lv[3:0]);
                  n = 12'h001 << (lv - 1);
                  p = bt ? n - 12'h001 + k[11:0] : 12'h000 - n - k[11:0];
                  if (lv == 0 || lv > 12)
                     p = k ? 12'hFFF : 12'h000;
                  opc({CMD_SE4, 4'h0, p, 16'h0}, 40,
                     exp_prot(iv[0], bt[0], lv[3:0], p), {4'h0, p, 16'h0});
               end
      frm({CMD_EXIT4, 32'h0}, 8);
      $display("protection test done");
   endtask
   task automatic t_rst();
      frm({CMD_WR_EXT, 8'h33, 24'h0}, 16);
      @(posedge mclk);
      strap <= 1'b1;
      frm({CMD_RST_EN, 32'h0}, 8);
      frm({CMD_RD_EXT, 32'h0}, 16);
      frm({CMD_RST, 32'h0}, 8);
      `CHK(ubyte, 8'h33)
      frm({CMD_RST_EN, 32'h0}, 8);
      frm({CMD_RST, 32'h0}, 8);
      `CHK(ubyte, EXT_RESET)
      `CHK(flag, 1'b1)
      frm({CMD_WR_EXT, 8'h44, 24'h0}, 16);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      `CHK(ubyte, EXT_RESET)
      `CHK(flag, 1'b1)
      $display("reset test done");
   endtask
   task automatic end_of_test();
      $display("%0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // main sequence: reset held ten cycles, then every scenario in turn
   initial
   begin
      mclk = 1'b0;
      rst = 1'b1;
      {inv, bot, strap, lvl} = 7'h00;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      t_ext();
      t_addr();
      t_prot();
      t_rst();
      end_of_test();
   end
   // about 150 frames of 2 us each are expected; allow twice that
   initial
   begin
      #600000;
      mismatches++;
      end_of_test();
   end
endmodule
`undef CHK
`default_nettype wire

// ==== faebp_host_model.sv ====
// host side of the serial link: frames instructions on sclk and cs_n
// assumes clock mode 0, msb first, device answering on so_i
`default_nettype none
module faebp_host_model
(
   output logic sclk_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_n_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: clock still and low, select high; select is raised once at
   // the start because the link's frame-start flop has no reset and
   // would miss an edge that lands in the same step as its own start
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b0;
      si_o = 1'b0;
      #1 cs_n_o = 1'b1;
   end
   // whole bytes, read data gathered after the command
   task automatic xfer(input logic [39:0] d, input int n,
      output logic [7:0] rd);
      rd = 8'h00;
      #5 cs_n_o = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         si_o = d[39 - i];
         #24 sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
         if (i >= 7 && i < 15)
            rd = {rd[6:0], so_oe_n_i ? 1'bx : so_i};
      end
      #24 cs_n_o = 1'b1;
      // released line flips so stale data is never mistaken for valid
      si_o = ~si_o;
      #48;
   endtask
endmodule
`default_nettype wire

// ==== faebp_pkg.sv ====
// shared constants and carrier types for the address extension and
// array protection block of a serial NOR flash.
// assumes a single-bit serial link framed by an active-low chip select.
`default_nettype none

package faebp_pkg;

   // ****************************************************************
   // instruction codes
   // ****************************************************************
   localparam logic [7:0] CMD_RD_EXT = 8'hC8;
   localparam logic [7:0] CMD_WR_EXT = 8'hC5;
   localparam logic [7:0] CMD_ENTER4 = 8'hB7;
   localparam logic [7:0] CMD_EXIT4 = 8'hE9;
   localparam logic [7:0] CMD_RST_EN = 8'h66;
   localparam logic [7:0] CMD_RST = 8'h99;
   localparam logic [7:0] CMD_PP = 8'h02;
   localparam logic [7:0] CMD_QPP = 8'h32;
   localparam logic [7:0] CMD_PP4 = 8'h12;
   localparam logic [7:0] CMD_SE = 8'h20;
   localparam logic [7:0] CMD_SE4 = 8'h21;
   localparam logic [7:0] CMD_BE32 = 8'h52;
   localparam logic [7:0] CMD_BE64 = 8'hD8;
   localparam logic [7:0] CMD_BE64_4 = 8'hDC;
   localparam logic [7:0] CMD_CE_A = 8'hC7;
   localparam logic [7:0] CMD_CE_B = 8'h60;

   // ****************************************************************
   // frame bit counts and field positions
   // ****************************************************************
   localparam logic [5:0] BITS_CMD = 6'h08;
   localparam logic [5:0] BITS_WR_EXT = 6'h10;
   localparam logic [5:0] BITS_ADDR3 = 6'h20;
   localparam logic [5:0] BITS_ADDR4 = 6'h28;
   localparam logic [5:0] BITS_MAX = 6'h3F;
   localparam int BLK_LSB = 16;
   localparam int BLK_MSB = 27;

   // ****************************************************************
   // reset values and protection decode constants
   // ****************************************************************
   localparam logic [7:0] EXT_RESET = 8'h00;
   localparam logic [11:0] BLK_FIRST = 12'h000;
   localparam logic [11:0] BLK_LAST = 12'hFFF;
   localparam logic [11:0] BLK_ONE = 12'h001;
   localparam logic [3:0] LEVEL_NONE = 4'h0;
   localparam logic [3:0] LEVEL_FULL = 4'hD;

   // ****************************************************************
   // carrier types
   // ****************************************************************
   typedef enum logic [2:0] {
      OPK_NONE = 3'h0,
      OPK_PAGE = 3'h1,
      OPK_SECT = 3'h3,
      OPK_BLK32 = 3'h2,
      OPK_BLK64 = 3'h6,
      OPK_CHIP = 3'h7
   } faebp_kind_t;

   typedef struct packed {
      logic valid;
      logic reject;
      faebp_kind_t kind;
      logic [31:0] addr;
   } faebp_op_t;

   typedef struct packed {
      logic any;
      logic [11:0] lo;
      logic [11:0] hi;
   } faebp_prot_t;

   localparam faebp_op_t OP_IDLE = '{1'b0, 1'b0, OPK_NONE, 32'h00000000};

endpackage

`default_nettype wire

// ==== faebp_prot_dec.sv ====
// protection decoder: turns invert, bottom and level bits into one
// inclusive range of protected 64 KB blocks.
// assumes the control bits are stable on the core clock.
`default_nettype none

module faebp_prot_dec
   import faebp_pkg::*;
(
   input wire logic invert_i,
   input wire logic from_bottom_i,
   input wire logic [3:0] level_i,
   output faebp_prot_t range_o
);

   logic [11:0] size;
   logic mid;

   // ****************************************************************
   // range decode
   // ****************************************************************
   // levels 1..12 cover a power of two of blocks from one end
   always_comb
   begin
      size = BLK_ONE << (level_i - 4'h1);
      mid = (level_i != LEVEL_NONE) && (level_i < LEVEL_FULL);
      range_o = '{1'b0, BLK_FIRST, BLK_FIRST};
      if (!invert_i)
      begin
         if (level_i >= LEVEL_FULL)
            range_o = '{1'b1, BLK_FIRST, BLK_LAST};
         else if (mid && from_bottom_i)
            range_o = '{1'b1, BLK_FIRST, size - BLK_ONE};
         else if (mid)
            range_o = '{1'b1, BLK_LAST - size + BLK_ONE, BLK_LAST};
         // level zero protects nothing either way
      end
      else
      begin
         // bottom flag ignored at level zero
         if (level_i == LEVEL_NONE)
            range_o = '{1'b1, BLK_FIRST, BLK_LAST};
         else if (mid && from_bottom_i)
            range_o = '{1'b1, size, BLK_LAST};
         else if (mid)
            range_o = '{1'b1, BLK_FIRST, BLK_LAST - size};
         // levels 13 to 15 invert to nothing
      end
   end

endmodule

`default_nettype wire
